// file: rtl/gpio_params.svh
// register offsets, access codes, trigger codes and reset values of the pin port controller
`ifndef GPIO_PARAMS_SVH
`define GPIO_PARAMS_SVH
// byte offsets of each register group; +0 word, +4 set, +8 clear, +c toggle
`define OFS_SW_CTRL 12'h000
`define OFS_FSEL_LSB 12'h010
`define OFS_FSEL_MSB 12'h020
`define OFS_DRIVE_EN 12'h040
`define OFS_OUT_LVL 12'h050
`define OFS_LEVEL_RB 12'h060
`define OFS_PULLUP 12'h070
`define OFS_IRQ_EN 12'h090
`define OFS_TRIG_LSB 12'h0a0
`define OFS_TRIG_MSB 12'h0b0
`define OFS_FILTER 12'h0c0
`define OFS_IRQ_FLAG 12'h0d0
`define OFS_EVENT_EN 12'h0e0
// access kind, taken from byte offset bits 3:2
`define ACC_WORD 2'h0
`define ACC_SET 2'h1
`define ACC_CLR 2'h2
`define ACC_TGL 2'h3
// trigger mode codes {msb,lsb}
`define TRG_ANY 2'h0
`define TRG_RISE 2'h1
`define TRG_FALL 2'h2
// reset values
`define RST_SW_CTRL 32'hffffffff
`define RST_ZERO 32'h00000000
// pins per interrupt or event group
`define GROUP_PINS 8
`endif

// file: rtl/gpio_pin_port_controller.sv
// 32-pin port controller: software/peripheral muxing, readback, edge detection, irq and events
//
// Summary of operation
// - 32 pins per port; word/set/clear/toggle writes
// - set, clear, toggle touch only one bits
// - absent pins ignore writes, read zero
// - readback refreshed only when software or irq enabled
// - peripheral mode: selected function drives pin
// - software mode: drive enable bit drives pin
// - software mode: driven level is output bit
// - two select bits pick function A to D
// - peripheral owns pull-up if supported, else register
// - pull-up register one enables, zero disables
// - output set/clear alias same timing as write
// - irq enable works in either pin mode
// - trigger on change, rising or falling edge
// - eight pins per irq group, four lines
// - irq flag sticky until software writes zero, or one to clear alias
// - detection runs only while clock runs
// - filter rejects one-cycle glitches, passes two
// - filter adds two cycles of latency
// - filter only on detection path
// - level counts once sampled, twice if filtered
// - local bus reaches output and drive registers
// - event enable emits events, irq not needed
// - events ORed in groups of eight, four lines
`include "gpio_params.svh"
`default_nettype none
module gpio_pin_port_controller #(
	parameter logic [31:0] PIN_MASK = 32'hffffffff,
	parameter int NUM_FUNC = 4
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [9:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic lb_write,
	input wire logic [11:0] lb_addr,
	input wire logic [31:0] lb_wdata,
	output logic [31:0] lb_rdata,
	input wire gpio_pkg::pin_vec_t pin_in,
	output gpio_pkg::pin_vec_t pin_out,
	output gpio_pkg::pin_vec_t pin_oe,
	output gpio_pkg::pin_vec_t pin_pullup,
	input wire gpio_pkg::periph_ctl_t periph_ctl [NUM_FUNC],
	output gpio_pkg::pin_vec_t periph_in,
	output logic [3:0] irq,
	output logic [3:0] event_out
);
	import gpio_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// bus front end
	logic [11:0] boff;
	logic pb_we;
	pin_vec_t be_mask;
	logic waitrequest_q;
	logic [31:0] readdata_q;
	logic [31:0] lb_rdata_q;
	pin_vec_t sw_ctrl_q, fsel_lsb_q, fsel_msb_q, drive_en_q, out_lvl_q, level_rb_q;
	pin_vec_t pullup_q, irq_en_q, trig_lsb_q, trig_msb_q, filter_q, irq_flag_q, event_en_q;

	assign boff = {address, 2'b00};
	// a write commits only at the edge where the master sees waitrequest low
	assign pb_we = write && !waitrequest_q;
	assign be_mask = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}},
		{8{byteenable[0]}}};

	// next value of one register group for one access; absent pins never change
	function automatic pin_vec_t upd(pin_vec_t old, logic [11:0] base, logic [11:0] a,
			logic en, pin_vec_t d, pin_vec_t m);
		pin_vec_t r;
		r = old;
		if (en && a[11:4] == base[11:4]) begin
			case (a[3:2])
				`ACC_WORD: r = (old & ~m) | (d & m);
				`ACC_SET: r = old | (d & m);
				`ACC_CLR: r = old & ~(d & m);
				`ACC_TGL: r = old ^ (d & m);
				default: r = old;
			endcase
		end
		return r & PIN_MASK;
	endfunction : upd

	// peripheral-bus-only register with all four access kinds
	function automatic pin_vec_t pb_upd(pin_vec_t old, logic [11:0] base);
		return upd(old, base, boff, pb_we, writedata, be_mask);
	endfunction : pb_upd

	// local bus is applied after the peripheral bus, so it wins on a same-cycle clash
	function automatic pin_vec_t both_upd(pin_vec_t old, logic [11:0] base);
		return upd(pb_upd(old, base), base, lb_addr, lb_write, lb_wdata, 32'hffffffff);
	endfunction : both_upd

	// register readback; unmapped offsets and alias slots other than +0 read zero
	function automatic logic [31:0] rd(logic [11:0] a);
		logic [31:0] r;
		r = 32'h00000000;
		if (a[3:2] == `ACC_WORD) begin
			case ({a[11:4], 4'h0})
				`OFS_SW_CTRL: r = sw_ctrl_q;
				`OFS_FSEL_LSB: r = fsel_lsb_q;
				`OFS_FSEL_MSB: r = fsel_msb_q;
				`OFS_DRIVE_EN: r = drive_en_q;
				`OFS_OUT_LVL: r = out_lvl_q;
				`OFS_LEVEL_RB: r = level_rb_q;
				`OFS_PULLUP: r = pullup_q;
				`OFS_IRQ_EN: r = irq_en_q;
				`OFS_TRIG_LSB: r = trig_lsb_q;
				`OFS_TRIG_MSB: r = trig_msb_q;
				`OFS_FILTER: r = filter_q;
				`OFS_IRQ_FLAG: r = irq_flag_q;
				`OFS_EVENT_EN: r = event_en_q;
				default: r = 32'h00000000;
			endcase
		end
		return r & PIN_MASK;
	endfunction : rd

	// one wait state on every access: answer is ready one edge after the request appears
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			waitrequest_q <= 1'b1;
		end else begin
			waitrequest_q <= !((read || write) && waitrequest_q);
		end
	end

	// read data is loaded on the edge that drops waitrequest and stands through it
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			readdata_q <= 32'h00000000;
		end else if (read && waitrequest_q) begin
			readdata_q <= rd(boff);
		end
	end

	// local bus read port: registered readback of the addressed output or drive register
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			lb_rdata_q <= 32'h00000000;
		end else if ({lb_addr[11:4], 4'h0} == `OFS_OUT_LVL ||
				{lb_addr[11:4], 4'h0} == `OFS_DRIVE_EN) begin
			lb_rdata_q <= rd({lb_addr[11:4], 4'h0});
		end else begin
			lb_rdata_q <= 32'h00000000;
		end
	end

	assign readdata = readdata_q;
	assign waitrequest = waitrequest_q;
	assign lb_rdata = lb_rdata_q;

	////////////////////////////////////////////////////////////////////////////////
	// configuration registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sw_ctrl_q <= `RST_SW_CTRL & PIN_MASK;
			fsel_lsb_q <= `RST_ZERO;
			fsel_msb_q <= `RST_ZERO;
			pullup_q <= `RST_ZERO;
		end else begin
			sw_ctrl_q <= pb_upd(sw_ctrl_q, `OFS_SW_CTRL);
			fsel_lsb_q <= pb_upd(fsel_lsb_q, `OFS_FSEL_LSB);
			fsel_msb_q <= pb_upd(fsel_msb_q, `OFS_FSEL_MSB);
			pullup_q <= pb_upd(pullup_q, `OFS_PULLUP);
		end
	end

	// output and drive registers, also reachable from the cpu local bus
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			drive_en_q <= `RST_ZERO;
			out_lvl_q <= `RST_ZERO;
		end else begin
			drive_en_q <= both_upd(drive_en_q, `OFS_DRIVE_EN);
			out_lvl_q <= both_upd(out_lvl_q, `OFS_OUT_LVL);
		end
	end

	// interrupt, trigger, filter and event configuration
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq_en_q <= `RST_ZERO;
			trig_lsb_q <= `RST_ZERO;
			trig_msb_q <= `RST_ZERO;
			filter_q <= `RST_ZERO;
			event_en_q <= `RST_ZERO;
		end else begin
			irq_en_q <= pb_upd(irq_en_q, `OFS_IRQ_EN);
			trig_lsb_q <= pb_upd(trig_lsb_q, `OFS_TRIG_LSB);
			trig_msb_q <= pb_upd(trig_msb_q, `OFS_TRIG_MSB);
			filter_q <= pb_upd(filter_q, `OFS_FILTER);
			event_en_q <= pb_upd(event_en_q, `OFS_EVENT_EN);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pin drive muxing
	pin_vec_t pout_d, poe_d, ppull_d;
	pin_vec_t pin_out_q, pin_oe_q, pin_pullup_q, periph_in_q;

	// per pin: software control or the function picked by the two select bits
	always_comb begin
		pout_d = '0;
		poe_d = '0;
		ppull_d = '0;
		for (int i = 0; i < 32; i++) begin
			logic [1:0] f;
			f = {fsel_msb_q[i], fsel_lsb_q[i]};
			if (sw_ctrl_q[i]) begin
				pout_d[i] = out_lvl_q[i];
				poe_d[i] = drive_en_q[i];
				ppull_d[i] = pullup_q[i];
			end else if (int'(f) < NUM_FUNC) begin
				pout_d[i] = periph_ctl[f].out[i];
				poe_d[i] = periph_ctl[f].oe[i];
				// pull-up stays with the register unless the function claims it
				ppull_d[i] = periph_ctl[f].pull_own[i] ? periph_ctl[f].pull_en[i]
					: pullup_q[i];
			end else begin
				ppull_d[i] = pullup_q[i];
			end
		end
	end

	// registered pin outputs; absent pins are never driven
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pin_out_q <= '0;
			pin_oe_q <= '0;
			pin_pullup_q <= '0;
		end else begin
			pin_out_q <= pout_d & PIN_MASK;
			pin_oe_q <= poe_d & PIN_MASK;
			pin_pullup_q <= ppull_d & PIN_MASK;
		end
	end

	// peripherals see the unfiltered level
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			periph_in_q <= '0;
		end else begin
			periph_in_q <= pin_in & PIN_MASK;
		end
	end

	assign pin_out = pin_out_q;
	assign pin_oe = pin_oe_q;
	assign pin_pullup = pin_pullup_q;
	assign periph_in = periph_in_q;

	////////////////////////////////////////////////////////////////////////////////
	// level readback and change detection
	pin_vec_t samp_q, samp2_q, filt_q, prev_q, lvl, trig;
	logic [3:0] irq_q, event_q;

	// readback only refreshes powered pins, saving toggling on idle ones
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			level_rb_q <= '0;
		end else begin
			level_rb_q <= ((pin_in & (sw_ctrl_q | irq_en_q)) |
				(level_rb_q & ~(sw_ctrl_q | irq_en_q))) & PIN_MASK;
		end
	end

	// every stage runs on clk, so nothing is detected while the clock is stopped
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			samp_q <= '0;
			samp2_q <= '0;
			filt_q <= '0;
			prev_q <= '0;
		end else begin
			samp_q <= pin_in & PIN_MASK;
			samp2_q <= samp_q;
			// filtered level moves only after two equal samples
			filt_q <= (samp_q & ~(samp_q ^ samp2_q)) | (filt_q & (samp_q ^ samp2_q));
			prev_q <= lvl;
		end
	end

	// toggling a filter bit may itself look like an edge on that pin
	assign lvl = (filter_q & filt_q) | (~filter_q & samp_q);

	// trigger per pin from the two mode bits; code 3 never fires
	always_comb begin
		trig = '0;
		for (int i = 0; i < 32; i++) begin
			case ({trig_msb_q[i], trig_lsb_q[i]})
				`TRG_ANY: trig[i] = lvl[i] ^ prev_q[i];
				`TRG_RISE: trig[i] = lvl[i] & ~prev_q[i];
				`TRG_FALL: trig[i] = ~lvl[i] & prev_q[i];
				default: trig[i] = 1'b0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// interrupt flags, group requests and events
	pin_vec_t flag_clr, flag_set;

	// word write clears flags written zero, clear alias clears flags written one
	always_comb begin
		flag_clr = '0;
		if (pb_we && {boff[11:4], 4'h0} == `OFS_IRQ_FLAG) begin
			if (boff[3:2] == `ACC_WORD) begin
				flag_clr = ~writedata & be_mask;
			end else if (boff[3:2] == `ACC_CLR) begin
				flag_clr = writedata & be_mask;
			end
		end
	end

	assign flag_set = trig & irq_en_q;

	// a new trigger in the clearing cycle wins over the clear
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq_flag_q <= '0;
		end else begin
			irq_flag_q <= ((irq_flag_q & ~flag_clr) | flag_set) & PIN_MASK;
		end
	end

	// group lines: irq levels from pending flags, events as one-cycle pulses
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq_q <= '0;
			event_q <= '0;
		end else begin
			for (int g = 0; g < 4; g++) begin
				irq_q[g] <= |(irq_flag_q[g*`GROUP_PINS +: `GROUP_PINS] &
					irq_en_q[g*`GROUP_PINS +: `GROUP_PINS]);
				event_q[g] <= |(trig[g*`GROUP_PINS +: `GROUP_PINS] &
					event_en_q[g*`GROUP_PINS +: `GROUP_PINS]);
			end
		end
	end

	assign irq = irq_q;
	assign event_out = event_q;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	sequence req_s;
		(read || write) && waitrequest_q;
	endsequence
	sequence glitch_s;
		!samp_q[0] && !samp2_q[0] && !filt_q[0] ##1 samp_q[0] ##1 !samp_q[0];
	endsequence

	bus_answer_a: assert property (@(posedge clk) disable iff (sys_rst)
		req_s |=> !waitrequest_q ##1 waitrequest_q)
		else $error("bus answer not one wait state");
	set_alias_a: assert property (@(posedge clk) disable iff (sys_rst)
		pb_we && boff == (`OFS_OUT_LVL | 12'h004) && !lb_write
		|=> (out_lvl_q & $past(writedata & be_mask & PIN_MASK))
			== $past(writedata & be_mask & PIN_MASK))
		else $error("set alias did not set bits");
	absent_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
		!waitrequest_q |-> (readdata_q & ~PIN_MASK) == 32'h00000000 &&
			(!$past(read && boff[11:4] > 8'h0e) || readdata_q == 32'h00000000))
		else $error("absent pin or unmapped offset read nonzero");
	readback_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
		((level_rb_q ^ $past(level_rb_q)) & ~$past(sw_ctrl_q | irq_en_q)) == '0)
		else $error("readback moved on unpowered pin");
	sw_drive_a: assert property (@(posedge clk) disable iff (sys_rst)
		sw_ctrl_q[0] |=> pin_oe_q[0] == $past(drive_en_q[0]))
		else $error("drive enable not followed");
	glitch_drop_a: assert property (@(posedge clk) disable iff (sys_rst)
		glitch_s |-> !filt_q[0] ##1 !filt_q[0])
		else $error("one-cycle glitch passed filter");
	flag_sticky_a: assert property (@(posedge clk) disable iff (sys_rst)
		irq_flag_q[0] && !flag_clr[0] |=> irq_flag_q[0])
		else $error("irq flag dropped without clear");
	group_irq_a: assert property (@(posedge clk) disable iff (sys_rst)
		|(irq_flag_q[7:0] & irq_en_q[7:0]) |=> irq_q[0])
		else $error("group request missing");
	event_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
		trig[8] && event_en_q[8] && !irq_en_q[8] |=> event_q[1] && !irq_flag_q[8])
		else $error("event not emitted");
endmodule : gpio_pin_port_controller
`default_nettype wire

// file: rtl/gpio_pkg.sv
// types shared by the pin port controller and its bench
`default_nettype none
package gpio_pkg;
	typedef logic [31:0] pin_vec_t;
	// one peripheral function's control of all 32 pins
	typedef struct packed {
		pin_vec_t out;
		pin_vec_t oe;
		pin_vec_t pull_en;
		pin_vec_t pull_own;
	} periph_ctl_t;
endpackage : gpio_pkg
`default_nettype wire

// file: test/periph_model.sv
// peripheral functions and pin pads facing the pin port controller
`default_nettype none
module periph_model (
	input wire gpio_pkg::pin_vec_t pin_out,
	input wire gpio_pkg::pin_vec_t pin_oe,
	input wire gpio_pkg::pin_vec_t pin_pullup,
	input wire gpio_pkg::pin_vec_t ext_lvl,
	output var gpio_pkg::pin_vec_t pin_in,
	output var gpio_pkg::periph_ctl_t periph_ctl [4]
);
	timeunit 1ns;
	timeprecision 1ps;
	import gpio_pkg::*;
	////////////////////////////////////////////////////////////////
	// pad: a driven pin shows its driver, an undriven one the pull-up or the outside level
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & (pin_pullup | ext_lvl));
	////////////////////////////////////////////////////////////////
	// four functions with distinct static patterns, so a wrong select shows at the pins
	always_comb begin
		for (int f = 0; f < 4; f++) begin
			periph_ctl[f].out = pin_vec_t'(32'h9e3779b9 * (f + 1));
			periph_ctl[f].oe = pin_vec_t'(32'hc2b2ae35 * (f + 3));
			periph_ctl[f].pull_en = pin_vec_t'(32'h5a5a3c3c << f);
			periph_ctl[f].pull_own = pin_vec_t'(32'h00ff0f0f << f);
		end
	end
endmodule : periph_model
`default_nettype wire

// file: test/tb.sv
// self-checking bench for the 32-pin port controller
`include "gpio_params.svh"
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import gpio_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic read = 1'b0;
	logic write = 1'b0;
	logic lb_write = 1'b0;
	logic [9:0] address = 10'h000;
	logic [31:0] writedata = 32'h0;
	logic [31:0] lb_wdata = 32'h0;
	logic [11:0] lb_addr = 12'h000;
	logic [31:0] readdata, lb_rdata, q, v, pu, eo;
	logic waitrequest;
	logic [3:0] irq, event_out, ev, iq;
	pin_vec_t pin_in, pin_out, pin_oe, pin_pullup, periph_in, sel;
	pin_vec_t ext_lvl = 32'h0;
	pin_vec_t regv [2];
	periph_ctl_t periph_ctl [4];
	int bad_count = 0;
	int checks_done = 0;
	int seed = 45;
	int k;
	gpio_pin_port_controller #(.NUM_FUNC(4)) DUT (.clk(clk), .sys_rst(sys_rst),
		.address(address), .read(read), .write(write), .writedata(writedata),
		.byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest),
		.lb_write(lb_write), .lb_addr(lb_addr), .lb_wdata(lb_wdata), .lb_rdata(lb_rdata),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
		.periph_ctl(periph_ctl), .periph_in(periph_in), .irq(irq), .event_out(event_out));
	periph_model partner (.pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
		.ext_lvl(ext_lvl), .pin_in(pin_in), .periph_ctl(periph_ctl));
	// 25 MHz clock
	always #20 clk = ~clk;
	////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : finish_test
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	// one avalon transfer; the request holds until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [11:0] ofs, input logic [31:0] d);
		int n;
		@(posedge clk);
		address <= ofs[11:2];
		write <= wr;
		read <= !wr;
		writedata <= d;
		for (n = 0; n < 20; n++) begin
			@(posedge clk);
			if (waitrequest === 1'b0)
				break;
		end
		if (n == 20) begin
			bad_count++;
			finish_test();
		end
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus
	function automatic logic [31:0] apply(input logic [1:0] a, input logic [31:0] o,
		input logic [31:0] d);
		case (a)
			`ACC_SET: return o | d;
			`ACC_CLR: return o & ~d;
			`ACC_TGL: return o ^ d;
			default: return d;
		endcase
	endfunction : apply
	// one level step or pulse on an undriven pin; flags, irq group and event group checked
	task automatic etest(input int p, input logic [1:0] m, input logic f, input int len,
		input logic ie, input logic ex);
		bus(1'b1, `OFS_TRIG_LSB, {32{m[0]}});
		bus(1'b1, `OFS_TRIG_MSB, {32{m[1]}});
		bus(1'b1, `OFS_FILTER, {32{f}});
		bus(1'b1, `OFS_IRQ_EN, {32{ie}});
		ext_lvl[p] <= 1'b0;
		repeat (6) @(posedge clk);
		bus(1'b1, `OFS_IRQ_FLAG, 32'h0);
		ev = 4'h0;
		iq = 4'h0;
		@(posedge clk);
		ext_lvl[p] <= 1'b1;
		for (int n = 0; n < 10; n++) begin
			@(posedge clk);
			if (n == len - 1)
				ext_lvl[p] <= 1'b0;
			ev = ev | event_out;
			iq = iq | irq;
		end
		bus(1'b0, `OFS_IRQ_FLAG, 32'h0);
		if (ie)
			check("irq flag", {31'h0, ex} << p, q);
		check("irq line", {3'h0, ex & ie} << (p / 8), iq);
		check("event line", {3'h0, ex} << (p / 8), ev);
		// writing zero to this pin only must clear its flag
		bus(1'b1, `OFS_IRQ_FLAG, ~(32'h1 << p));
		bus(1'b0, `OFS_IRQ_FLAG, 32'h0);
		check("flag cleared", 32'h0, q);
		$display("edge test done pin %0d mode %0d", p, m);
	endtask : etest
	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		bus(1'b0, `OFS_SW_CTRL, 32'h0);
		check("sw ctrl reset", `RST_SW_CTRL, q);
		bus(1'b0, 12'h3f0, 32'h0);
		check("unmapped", 32'h0, q);
		// random word and alias writes on drive and output registers
		regv[0] = 32'h0;
		regv[1] = 32'h0;
		for (int i = 0; i < 16; i++) begin
			k = $random(seed);
			v = $random(seed);
			bus(1'b1, (i[0] ? `OFS_OUT_LVL : `OFS_DRIVE_EN) + {8'h0, k[1:0], 2'h0}, v);
			regv[i[0]] = apply(k[1:0], regv[i[0]], v);
			bus(1'b0, i[0] ? `OFS_OUT_LVL : `OFS_DRIVE_EN, 32'h0);
			check("alias reg", regv[i[0]], q);
		end
		repeat (2) @(posedge clk);
		check("pin oe", regv[0], pin_oe);
		check("pin out", regv[1] & regv[0], pin_out & regv[0]);
		$display("register access test done");
		// local bus set alias
		v = $random(seed);
		@(posedge clk);
		lb_addr <= `OFS_OUT_LVL + 12'h4;
		lb_wdata <= v;
		lb_write <= 1'b1;
		@(posedge clk);
		lb_write <= 1'b0;
		regv[1] = regv[1] | v;
		repeat (2) @(posedge clk);
		check("lb pin out", regv[1] & regv[0], pin_out & regv[0]);
		check("lb rdata", regv[1], lb_rdata);
		bus(1'b0, `OFS_OUT_LVL, 32'h0);
		check("lb reg", regv[1], q);
		$display("local bus test done");
		// low half to peripherals, every function selected in turn
		sel = 32'hffff0000;
		pu = $random(seed);
		bus(1'b1, `OFS_PULLUP, pu);
		bus(1'b1, `OFS_SW_CTRL + 12'h8, ~sel);
		for (int f = 0; f < 4; f++) begin
			bus(1'b1, `OFS_FSEL_LSB, f[0] ? 32'hffffffff : 32'h0);
			bus(1'b1, `OFS_FSEL_MSB, f[1] ? 32'hffffffff : 32'h0);
			repeat (2) @(posedge clk);
			eo = (sel & regv[0]) | (~sel & periph_ctl[f].oe);
			check("mux oe", eo, pin_oe);
			v = (sel & regv[1]) | (~sel & periph_ctl[f].out);
			check("mux out", v & eo, pin_out & eo);
			v = ~sel & periph_ctl[f].pull_own;
			check("pullup", (v & periph_ctl[f].pull_en) | (~v & pu), pin_pullup);
		end
		$display("mux test done");
		// undriven pins without pull-up for the edge tests
		bus(1'b1, `OFS_SW_CTRL, 32'hffffffff);
		bus(1'b1, `OFS_DRIVE_EN, 32'h0);
		bus(1'b1, `OFS_PULLUP, 32'h0);
		bus(1'b1, `OFS_EVENT_EN, 32'hffffffff);
		etest(9, `TRG_ANY, 1'b0, 99, 1'b1, 1'b1);
		etest(9, `TRG_RISE, 1'b0, 99, 1'b1, 1'b1);
		etest(9, `TRG_FALL, 1'b0, 99, 1'b1, 1'b0);
		etest(9, 2'h3, 1'b0, 99, 1'b1, 1'b0);
		etest(0, `TRG_RISE, 1'b0, 1, 1'b1, 1'b1);
		etest(0, `TRG_RISE, 1'b1, 1, 1'b1, 1'b0);
		etest(17, `TRG_RISE, 1'b1, 2, 1'b1, 1'b1);
		etest(30, `TRG_ANY, 1'b1, 99, 1'b0, 1'b1);
		// readback ignores the filter; a pin out of software and irq control holds its bit
		v = $random(seed);
		@(posedge clk);
		ext_lvl <= v;
		repeat (3) @(posedge clk);
		bus(1'b0, `OFS_LEVEL_RB, 32'h0);
		check("readback", v, q);
		check("periph in", v, periph_in);
		// pin 0 goes to a function that leaves it undriven, so the outside level reaches it
		bus(1'b1, `OFS_SW_CTRL + 12'h8, 32'h1);
		ext_lvl[0] <= ~v[0];
		repeat (3) @(posedge clk);
		bus(1'b0, `OFS_LEVEL_RB, 32'h0);
		check("readback hold", v, q);
		$display("readback test done");
		finish_test();
	end
endmodule : tb
`default_nettype wire
